// ---- dv/imss_partner.sv ----
// Far side of the two-wire bus: pull-ups, an outside master and a slave transmitter.
`timescale 1ns/10ps
module imss_partner (
    // Clock
    input  wire logic i_clk,
    // Drive of the sequencer
    input  wire logic i_scl_oe,
    input  wire logic i_sda_oe,
    // Resolved lines
    output logic      o_scl,
    output logic      o_sda
);
    logic       scl_low_q  = 1'b0;
    logic       sda_low_q  = 1'b0;
    logic       slv_en_q   = 1'b0;
    logic [7:0] slv_byte_q = 8'h00;
    logic [3:0] slv_cnt_q  = 4'h0;
    logic       scl_prev_q = 1'b1;
    logic       slv_low;

    // Both lines have pull-ups, so a released line reads high.
    assign slv_low = slv_en_q && (slv_cnt_q < 4'h8) && !slv_byte_q[3'h7 - slv_cnt_q[2:0]];
    assign o_scl   = ~i_scl_oe & ~scl_low_q;
    assign o_sda   = ~i_sda_oe & ~sda_low_q & ~slv_low;

    // The slave moves to its next bit only after the clock falls, MSB first.
    always @(posedge i_clk) begin
        scl_prev_q <= o_scl;
        if (slv_en_q && scl_prev_q && !o_scl && slv_cnt_q < 4'h8) begin
            slv_cnt_q <= slv_cnt_q + 4'h1;
        end
    end

    task automatic half();
        repeat (4) @(posedge i_clk);
    endtask

    // The outside master keeps 160 ns halves, a 320 ns bus clock.
    task automatic ext_start();
        sda_low_q <= 1'b1;
        half();
        scl_low_q <= 1'b1;
        half();
    endtask

    task automatic ext_byte(input logic [7:0] b);
        for (int i = 8; i >= 0; i--) begin
            sda_low_q <= (i > 0) ? ~b[i-1] : 1'b0;
            half();
            scl_low_q <= 1'b0;
            half();
            scl_low_q <= 1'b1;
        end
    endtask

    task automatic ext_stop();
        sda_low_q <= 1'b1;
        half();
        scl_low_q <= 1'b0;
        half();
        sda_low_q <= 1'b0;
        half();
    endtask

    task automatic slave_send(input logic [7:0] b);
        slv_byte_q <= b;
        slv_cnt_q  <= 4'h0;
        slv_en_q   <= 1'b1;
    endtask

    task automatic hold_sda(input logic v);
        sda_low_q <= v;
    endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the two-wire sequencer and its status flags.
`timescale 1ns/10ps
module tb_top;
    localparam logic [15:0] M_GC = 16'h0001 << imss_pkg::SB_GC;
    localparam logic [15:0] M_DA = 16'h0001 << imss_pkg::SB_DA;
    localparam logic [15:0] M_OV = 16'h0001 << imss_pkg::SB_OV;
    localparam logic [15:0] M_FL = 16'h0001 << imss_pkg::SB_FULL;
    localparam logic [15:0] M_BC = 16'h0001 << imss_pkg::SB_BCL;
    localparam logic [15:0] M_TB = 16'h0001 << imss_pkg::SB_A10;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic [3:0]  adr  = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic        ce   = 1'b1;
    logic [3:0]  sel  = 4'h3;
    logic        pin_scl;
    logic        pin_sda;
    logic        ack;
    logic [31:0] rdat;
    logic        scl;
    logic        sda;
    logic        scl_oe;
    logic        sda_oe;
    logic        rec_en    = 1'b0;
    logic        seen_sda  = 1'b0;
    logic        saw_start = 1'b0;
    logic [15:0] r;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    imss_top #(.QTR(4)) u_imss_top (.i_clk(clk), .i_reset(rst), .i_ce(ce),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat), .i_scl(scl), .i_sda(sda),
        .o_scl(pin_scl), .o_scl_oe(scl_oe), .o_sda(pin_sda), .o_sda_oe(sda_oe));
    imss_partner u_imss_partner (.i_clk(clk), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe),
        .o_scl(scl), .o_sda(sda));

    initial begin
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Watchers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (rec_en && scl_oe === 1'b0) seen_sda = sda_oe;
        if (sda_oe === 1'b1 && scl_oe === 1'b0) saw_start = 1'b1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
                      output logic [15:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {16'h0000, d};
        // Only the bench-wide cycle ceiling ends a wait for the answer.
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
        wb(1'b0, a, 16'h0000, r);
        chk(r, exp);
    endtask

    // Polls the control register until the request bit falls, before any new request.
    task automatic wait_clr(input int b);
        do begin
            wb(1'b0, imss_pkg::OFS_CTRL, 16'h0000, r);
        end while (r[b] !== 1'b0);
        chk({15'h0000, r[b]}, 16'h0000);
    endtask

    task automatic done(input string s);
        $display("test %s ended, mismatches so far %0d", s, num_errors);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk_reg(imss_pkg::OFS_CTRL, 16'h0000);
        chk_reg(imss_pkg::OFS_STAT, 16'h0000);
        chk_reg(imss_pkg::OFS_OWN, 16'h0000);
        chk_reg(4'h2, 16'h0000);
        // Only the enabled byte lane may take write data.
        sel <= 4'h1;
        wr(imss_pkg::OFS_OWN, 16'hFFFF);
        chk_reg(imss_pkg::OFS_OWN, 16'h00FF);
        sel <= 4'h3;
        wr(imss_pkg::OFS_OWN, 16'h0000);
        chk_reg(imss_pkg::OFS_OWN, 16'h0000);
        done("reset");
    endtask

    task automatic t_gcall();
        u_imss_partner.ext_start();
        u_imss_partner.ext_byte(8'h00);
        chk_reg(imss_pkg::OFS_STAT, M_GC);
        u_imss_partner.ext_byte(8'h3C);
        chk_reg(imss_pkg::OFS_STAT, M_GC | M_DA | M_FL);
        u_imss_partner.ext_byte(8'h55);
        chk_reg(imss_pkg::OFS_STAT, M_GC | M_DA | M_FL | M_OV);
        chk_reg(imss_pkg::OFS_RXD, 16'h003C);
        wr(imss_pkg::OFS_STAT, 16'h0000);
        chk_reg(imss_pkg::OFS_STAT, M_GC | M_DA);
        u_imss_partner.ext_stop();
        chk_reg(imss_pkg::OFS_STAT, M_DA);
        done("general_call");
    endtask

    task automatic t_tenbit();
        wr(imss_pkg::OFS_OWN, 16'h82A5);
        u_imss_partner.ext_start();
        u_imss_partner.ext_byte(8'hF4);
        wb(1'b0, imss_pkg::OFS_STAT, 16'h0000, r);
        chk(r & M_TB, 16'h0000);
        u_imss_partner.ext_byte(8'hA5);
        chk_reg(imss_pkg::OFS_STAT, M_TB);
        u_imss_partner.ext_stop();
        chk_reg(imss_pkg::OFS_STAT, 16'h0000);
        done("ten_bit");
    endtask

    task automatic t_collide();
        u_imss_partner.hold_sda(1'b1);
        wr(imss_pkg::OFS_CTRL, 16'h0001 << imss_pkg::CB_START);
        wait_clr(imss_pkg::CB_START);
        chk_reg(imss_pkg::OFS_STAT, M_BC);
        u_imss_partner.hold_sda(1'b0);
        wr(imss_pkg::OFS_STAT, 16'h0000);
        chk_reg(imss_pkg::OFS_STAT, 16'h0000);
        done("collision");
    endtask

    task automatic t_start();
        saw_start = 1'b0;
        wr(imss_pkg::OFS_CTRL, 16'h0001 << imss_pkg::CB_START);
        // A low enable must hold the sequencer where it stands.
        ce <= 1'b0;
        repeat (40) @(posedge clk);
        chk({14'h0000, sda_oe, scl_oe}, 16'h0000);
        ce <= 1'b1;
        wait_clr(imss_pkg::CB_START);
        chk({15'h0000, saw_start}, 16'h0001);
        chk({14'h0000, sda_oe, scl_oe}, 16'h0003);
        chk({14'h0000, pin_sda, pin_scl}, 16'h0000);
        done("start");
    endtask

    task automatic t_receive();
        u_imss_partner.slave_send(8'hA5);
        wr(imss_pkg::OFS_CTRL, 16'h0001 << imss_pkg::CB_RCV);
        wait_clr(imss_pkg::CB_RCV);
        chk_reg(imss_pkg::OFS_RXD, 16'h00A5);
        done("receive");
    endtask

    task automatic t_ack();
        for (int v = 1; v >= 0; v--) begin
            seen_sda = v[0];
            rec_en   = 1'b1;
            wr(imss_pkg::OFS_CTRL, (16'h0001 << imss_pkg::CB_ACK) |
               (16'(v) << imss_pkg::CB_ACKV));
            wait_clr(imss_pkg::CB_ACK);
            rec_en = 1'b0;
            chk({15'h0000, seen_sda}, {15'h0000, ~v[0]});
        end
        done("acknowledge");
    endtask

    task automatic t_rst_stop();
        saw_start = 1'b0;
        wr(imss_pkg::OFS_CTRL, 16'h0001 << imss_pkg::CB_RST);
        wait_clr(imss_pkg::CB_RST);
        chk({15'h0000, saw_start}, 16'h0001);
        wr(imss_pkg::OFS_CTRL, 16'h0001 << imss_pkg::CB_STOP);
        wait_clr(imss_pkg::CB_STOP);
        chk({14'h0000, scl, sda}, 16'h0003);
        chk({14'h0000, sda_oe, scl_oe}, 16'h0000);
        done("restart_stop");
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gcall();
        t_tenbit();
        t_collide();
        t_start();
        t_receive();
        t_ack();
        t_rst_stop();
        stop_test();
    end
endmodule

// ---- hdl/imss_pkg.sv ----
// Shared constants, register map and types of the two-wire sequencer.
package imss_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS  = 40;
    localparam int QTR_NS  = 2500;
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int PH_END  = 4;
    localparam int RX_LAST = 7;
    localparam int MON_ACK = 8;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_RXD  = 4'h8;
    localparam logic [3:0] OFS_OWN  = 4'hC;
    // Control bits.
    localparam int CB_START = 0;
    localparam int CB_RST   = 1;
    localparam int CB_STOP  = 2;
    localparam int CB_RCV   = 3;
    localparam int CB_ACK   = 4;
    localparam int CB_ACKV  = 5;
    // Status bits.
    localparam int SB_FULL  = 1;
    localparam int SB_DA    = 5;
    localparam int SB_OV    = 6;
    localparam int SB_A10   = 8;
    localparam int SB_GC    = 9;
    localparam int SB_BCL   = 10;
    // Own-address register: ten-bit enable and address.
    localparam int OB_TEN   = 15;
    localparam logic [5:0]  CTRL_RST = 6'h00;
    localparam logic [15:0] OWN_RST  = 16'h0000;
    localparam logic [7:0]  GC_ADDR  = 8'h00;
    localparam logic [4:0]  TEN_PFX  = 5'h1E;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } imss_line_s;
    typedef enum logic [2:0] {S_IDLE, S_START, S_RST, S_STOP, S_RX, S_ACK} imss_state_e;
endpackage

// ---- hdl/imss_top.sv ----
// Two-wire bus master sequencer with slave address monitor and status flags.
//
// Behaviour
// - During acknowledge, data line carries ack value: 1 gives NACK, 0 gives ACK.
// - Acknowledge request runs an acknowledge sequence; hardware clears it when done.
// - Receive request clocks in one byte; cleared after the eighth data bit.
// - Stop request makes a stop condition; cleared when the stop finishes.
// - Restart request makes a repeated start; cleared when it completes.
// - Start request makes a start condition; cleared at the end of start.
// - Bus collision during start, restart or stop sequences sets a sticky flag software clears.
// - General call address received sets a flag; stop condition clears it.
// - Matching second byte of ten-bit address sets a flag; stop clears it.
// - A byte arriving while holding register is full sets overflow; software clears.
// - Slave data byte sets data flag; own address match clears it.
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module imss_top #(
    parameter int QTR = imss_pkg::QTR_CYC
) (
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic             o_wb_ack,
    output logic [31:0]      o_wb_dat,
    // Bus lines, open drain
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_scl,
    output logic             o_scl_oe,
    output logic             o_sda,
    output logic             o_sda_oe
);
    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    imss_pkg::imss_line_s sync1_q, sync2_q, prev_q, oe_q;
    imss_pkg::imss_state_e st_q;
    logic [7:0]  qcnt_q;
    logic [2:0]  ph_q;
    logic [2:0]  bitn_q;
    logic [7:0]  rsh_q, msh_q, rxd_q;
    logic [5:0]  ctrl_q;
    logic [15:0] own_q;
    logic [3:0]  mcnt_q;
    logic [1:0]  idx_q;
    logic        mast_q, ten_hi_q, matched_q;
    logic        bcl_q, gc_q, a10_q, ov_q, da_q, full_q;
    logic        tick, done, col, wr, rd;
    logic        start_det, stop_det, rise, byte_ev, addr_hit, a10_hit, data_ev, ld;
    logic [7:0]  mbyte, ld_byte;
    logic [15:0] rdv;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q  <= '1;
        end else if (i_ce) begin
            sync1_q <= '{scl: i_scl, sda: i_sda};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign start_det = sync2_q.scl & prev_q.scl & prev_q.sda & ~sync2_q.sda;
    assign stop_det  = sync2_q.scl & prev_q.scl & ~prev_q.sda & sync2_q.sda;
    assign rise      = sync2_q.scl & ~prev_q.scl;

    // ------------------------------------------------------------
    // Master sequencer
    // ------------------------------------------------------------
    // Pull-low enables for each quarter of a sequence; 1 drives the line low.
    function automatic imss_pkg::imss_line_s drv(imss_pkg::imss_state_e s, logic [2:0] p,
                                                 logic ackv);
        logic [1:0] r;
        r = 2'b00;
        unique case (s)
            imss_pkg::S_START: r = (p == 3'h0) ? 2'b00 : (p == 3'h1) ? 2'b01 : 2'b11;
            imss_pkg::S_RST:   r = (p == 3'h0) ? 2'b10 : (p == 3'h1) ? 2'b00 :
                                   (p == 3'h2) ? 2'b01 : 2'b11;
            imss_pkg::S_STOP:  r = (p == 3'h0) ? 2'b11 : (p == 3'h1) ? 2'b01 : 2'b00;
            imss_pkg::S_RX:    r = (p == 3'h1 || p == 3'h2) ? 2'b00 : 2'b10;
            imss_pkg::S_ACK:   r = {(p == 3'h0 || p == 3'h3), ~ackv};
            imss_pkg::S_IDLE:  r = 2'b00;
        endcase
        return '{scl: r[1], sda: r[0]};
    endfunction

    assign tick = i_ce & (qcnt_q == 8'(QTR - 1));
    assign done = tick & (st_q != imss_pkg::S_IDLE) & (ph_q == 3'(imss_pkg::PH_END))
                & ((st_q != imss_pkg::S_RX) | (bitn_q == 3'(imss_pkg::RX_LAST)));
    // Only conditions have a defined released-high data line while clock is released.
    assign col  = tick & (st_q == imss_pkg::S_START || st_q == imss_pkg::S_RST
                || st_q == imss_pkg::S_STOP) & ~oe_q.scl & ~oe_q.sda & ~sync2_q.sda;

    always_ff @(posedge i_clk) begin
        if (i_reset || tick) begin
            qcnt_q <= 8'h00;
        end else if (i_ce) begin
            qcnt_q <= qcnt_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q   <= imss_pkg::S_IDLE;
            ph_q   <= 3'h0;
            bitn_q <= 3'h0;
            oe_q   <= '0;
            rsh_q  <= 8'h00;
            o_scl  <= 1'b0;
            o_sda  <= 1'b0;
        end else if (col) begin
            st_q <= imss_pkg::S_IDLE;
            oe_q <= '0;
        end else if (tick) begin
            if (st_q == imss_pkg::S_IDLE) begin
                ph_q   <= 3'h0;
                bitn_q <= 3'h0;
                if (ctrl_q[imss_pkg::CB_START]) st_q <= imss_pkg::S_START;
                else if (ctrl_q[imss_pkg::CB_RST]) st_q <= imss_pkg::S_RST;
                else if (ctrl_q[imss_pkg::CB_STOP]) st_q <= imss_pkg::S_STOP;
                else if (ctrl_q[imss_pkg::CB_RCV]) st_q <= imss_pkg::S_RX;
                else if (ctrl_q[imss_pkg::CB_ACK]) st_q <= imss_pkg::S_ACK;
            end else if (ph_q == 3'(imss_pkg::PH_END)) begin
                ph_q <= 3'h0;
                if (done) begin
                    st_q <= imss_pkg::S_IDLE;
                end else begin
                    bitn_q <= bitn_q + 3'h1;
                end
            end else begin
                oe_q <= drv(st_q, ph_q, ctrl_q[imss_pkg::CB_ACKV]);
                ph_q <= ph_q + 3'h1;
                if (st_q == imss_pkg::S_RX && ph_q == 3'h2) begin
                    rsh_q <= {rsh_q[6:0], sync2_q.sda};
                end
            end
        end
    end

    // Bus ownership, so the monitor ignores traffic this block makes.
    always_ff @(posedge i_clk) begin
        if (i_reset || col) begin
            mast_q <= 1'b0;
        end else if (done) begin
            if (st_q == imss_pkg::S_START || st_q == imss_pkg::S_RST) mast_q <= 1'b1;
            else if (st_q == imss_pkg::S_STOP) mast_q <= 1'b0;
        end
    end

    assign o_scl_oe = oe_q.scl;
    assign o_sda_oe = oe_q.sda;

    // ------------------------------------------------------------
    // Slave address monitor
    // ------------------------------------------------------------
    assign mbyte    = {msh_q[6:0], sync2_q.sda};
    assign byte_ev  = i_ce & rise & ~mast_q & (mcnt_q == 4'(imss_pkg::RX_LAST));
    assign addr_hit = byte_ev & (idx_q == 2'h0) & ((mbyte == imss_pkg::GC_ADDR)
                    | (~own_q[imss_pkg::OB_TEN] & (mbyte[7:1] == own_q[6:0])));
    assign a10_hit  = byte_ev & (idx_q == 2'h1) & ten_hi_q & (mbyte == own_q[7:0]);
    assign data_ev  = byte_ev & matched_q & (idx_q != 2'h0) & ~(idx_q == 2'h1 & ten_hi_q);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            msh_q     <= 8'h00;
            mcnt_q    <= 4'h0;
            idx_q     <= 2'h0;
            ten_hi_q  <= 1'b0;
            matched_q <= 1'b0;
        end else if (i_ce) begin
            if (start_det || stop_det) begin
                mcnt_q <= 4'h0;
                idx_q  <= 2'h0;
                if (stop_det) begin
                    ten_hi_q  <= 1'b0;
                    matched_q <= 1'b0;
                end
            end else if (rise) begin
                msh_q  <= mbyte;
                mcnt_q <= (mcnt_q == 4'(imss_pkg::MON_ACK)) ? 4'h0 : mcnt_q + 4'h1;
                if (mcnt_q == 4'(imss_pkg::MON_ACK) && idx_q != 2'h2) idx_q <= idx_q + 2'h1;
            end
            if (byte_ev && idx_q == 2'h0) begin
                ten_hi_q <= own_q[imss_pkg::OB_TEN] & (mbyte[7:3] == imss_pkg::TEN_PFX)
                          & (mbyte[2:1] == own_q[9:8]);
            end
            if (addr_hit || a10_hit) matched_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status flags and holding register
    // ------------------------------------------------------------
    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
    assign rd = i_wb_cyc & i_wb_stb & ~i_wb_we & ~o_wb_ack;
    assign ld = (done & (st_q == imss_pkg::S_RX)) | data_ev;
    assign ld_byte = data_ev ? mbyte : rsh_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_q <= imss_pkg::CTRL_RST;
            own_q  <= imss_pkg::OWN_RST;
        end else if (i_ce) begin
            if (wr && i_wb_adr == imss_pkg::OFS_CTRL && i_wb_sel[0]) begin
                ctrl_q <= i_wb_dat[5:0];
            end else if (col) begin
                ctrl_q[4:0] <= 5'h00;
            end else if (done) begin
                unique case (st_q)
                    imss_pkg::S_START: ctrl_q[imss_pkg::CB_START] <= 1'b0;
                    imss_pkg::S_RST:   ctrl_q[imss_pkg::CB_RST]   <= 1'b0;
                    imss_pkg::S_STOP:  ctrl_q[imss_pkg::CB_STOP]  <= 1'b0;
                    imss_pkg::S_RX:    ctrl_q[imss_pkg::CB_RCV]   <= 1'b0;
                    imss_pkg::S_ACK:   ctrl_q[imss_pkg::CB_ACK]   <= 1'b0;
                    imss_pkg::S_IDLE:  ctrl_q <= ctrl_q;
                endcase
            end
            if (wr && i_wb_adr == imss_pkg::OFS_OWN) begin
                if (i_wb_sel[0]) own_q[7:0]  <= i_wb_dat[7:0];
                if (i_wb_sel[1]) own_q[15:8] <= i_wb_dat[15:8];
            end
        end
    end

    // Software clears a sticky flag by writing 0; a same-cycle hardware set wins.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            bcl_q <= 1'b0;
            ov_q  <= 1'b0;
        end else if (i_ce) begin
            if (col) bcl_q <= 1'b1;
            else if (wr && i_wb_adr == imss_pkg::OFS_STAT && i_wb_sel[1]
                     && !i_wb_dat[imss_pkg::SB_BCL]) bcl_q <= 1'b0;
            if (ld && full_q) ov_q <= 1'b1;
            else if (wr && i_wb_adr == imss_pkg::OFS_STAT && i_wb_sel[0]
                     && !i_wb_dat[imss_pkg::SB_OV]) ov_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            gc_q  <= 1'b0;
            a10_q <= 1'b0;
            da_q  <= 1'b0;
        end else if (i_ce) begin
            if (byte_ev && idx_q == 2'h0 && mbyte == imss_pkg::GC_ADDR) gc_q <= 1'b1;
            else if (stop_det) gc_q <= 1'b0;
            if (a10_hit) a10_q <= 1'b1;
            else if (stop_det) a10_q <= 1'b0;
            if (data_ev) da_q <= 1'b1;
            else if (addr_hit || a10_hit) da_q <= 1'b0;
        end
    end

    // An overflowing byte is dropped; the unread byte is kept.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rxd_q  <= 8'h00;
            full_q <= 1'b0;
        end else if (i_ce) begin
            if (ld && !full_q) begin
                rxd_q  <= ld_byte;
                full_q <= 1'b1;
            end else if (rd && i_wb_adr == imss_pkg::OFS_RXD && !ld) begin
                full_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    always_comb begin
        rdv = 16'h0000;
        unique case (i_wb_adr)
            imss_pkg::OFS_CTRL: rdv = {10'h000, ctrl_q};
            imss_pkg::OFS_STAT: rdv = {5'h00, bcl_q, gc_q, a10_q, 1'b0, ov_q, da_q,
                                       3'h0, full_q, 1'b0};
            imss_pkg::OFS_RXD:  rdv = {8'h00, rxd_q};
            imss_pkg::OFS_OWN:  rdv = own_q;
            default:            rdv = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else if (i_ce) begin
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
            if (rd) o_wb_dat <= {16'h0000, rdv};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_ack_value: assert property ((st_q == imss_pkg::S_ACK && ph_q != 3'h0)
        |-> oe_q.sda == ~ctrl_q[imss_pkg::CB_ACKV]) else $error("ack value not driven");
    a_ack_clear: assert property ((done && st_q == imss_pkg::S_ACK && !wr)
        |=> !ctrl_q[imss_pkg::CB_ACK]) else $error("ack request not cleared");
    a_rx_byte: assert property ((done && st_q == imss_pkg::S_RX && !full_q && !wr)
        |=> full_q && rxd_q == $past(rsh_q) && !ctrl_q[imss_pkg::CB_RCV])
        else $error("receive byte not delivered");
    a_stop_clear: assert property ((done && st_q == imss_pkg::S_STOP && !wr)
        |=> !ctrl_q[imss_pkg::CB_STOP] && !mast_q) else $error("stop not closed");
    a_rst_clear: assert property ((done && st_q == imss_pkg::S_RST && !wr)
        |=> !ctrl_q[imss_pkg::CB_RST] && mast_q) else $error("restart not cleared");
    a_start_seq: assert property ((tick && st_q == imss_pkg::S_IDLE
        && ctrl_q[imss_pkg::CB_START]) |=> st_q == imss_pkg::S_START && ph_q == 3'h0)
        else $error("start not begun");
    a_bcl_set: assert property (col |=> bcl_q && st_q == imss_pkg::S_IDLE
        && !oe_q.scl && !oe_q.sda) else $error("collision not handled");
    a_gc_stop: assert property ((i_ce && stop_det) |=> !gc_q && !a10_q)
        else $error("stop did not clear flags");
    a_ten_match: assert property (a10_hit |=> a10_q && !da_q)
        else $error("ten-bit match not flagged");
    a_ovf_set: assert property ((ld && full_q) |=> ov_q && rxd_q == $past(rxd_q))
        else $error("overflow not flagged");
    a_da_set: assert property (data_ev |=> da_q) else $error("data flag not set");
    a_wb_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");

    c_start: cover property (done && st_q == imss_pkg::S_START);
    c_rx: cover property (done && st_q == imss_pkg::S_RX);
    c_col: cover property (col);
    c_gc: cover property ($rose(gc_q));
endmodule
